/* File: hdl/tcbsc_pkg.sv */
// Constants and carrier types of the bus switch control block
package tcbsc_pkg;

	// ****************************************
	// Byte framing
	// ****************************************
	localparam logic [3:0] BIT_CNT_RESET = 4'h0;
	localparam logic [3:0] BIT_CNT_FULL  = 4'h8;
	localparam logic [3:0] BIT_CNT_TXEND = 4'h7;

	// Upper address bits: arbitrary value, not taken from any part
	localparam logic [4:0] ADDR_UPPER = 5'h0E;

	// ****************************************
	// Control register
	// ****************************************
	typedef struct packed {
		logic [1:0] rsvdHigh;
		logic [1:0] irq;
		logic [1:0] rsvdLow;
		logic [1:0] sel;
	} tcbsc_ctrl_type;

	localparam logic [1:0]     SEL_RESET  = 2'h0;
	localparam logic [1:0]     IRQ_RESET  = 2'h0;
	localparam logic [1:0]     RSVD_VALUE = 2'h0;
	localparam tcbsc_ctrl_type CTRL_RESET = 8'h00;

	// ****************************************
	// Pin carriers
	// ****************************************
	typedef struct packed {
		logic scl;
		logic sda;
		logic irq1N;
		logic irq0N;
		logic rstN;
		logic addrHigh;
		logic addrLow;
	} tcbsc_pins_type;

	localparam int             PINS_W     = 7;
	localparam tcbsc_pins_type PINS_RESET = 7'h7F;

	typedef struct packed {
		logic sclRise;
		logic sclFall;
		logic start;
		logic stop;
		logic sclHigh;
		logic sda;
	} tcbsc_cond_type;

	localparam tcbsc_cond_type COND_RESET = 6'h03;

	// ****************************************
	// Bus state machine
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_DATA,
		ST_WR_ACK,
		ST_RD_DATA,
		ST_RD_ACK,
		ST_IGNORE
	} tcbsc_state_type;

endpackage

/* File: hdl/tcbsc_sync.sv */
// Two-stage synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
module tcbsc_sync
#(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	// ****************************************
	// One pair of flops per bit
	// ****************************************
	// Flops stay local so each output bit has exactly one driver
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic stage1;
			logic stage2;
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					stage1 <= RESET_VAL[i];
					stage2 <= RESET_VAL[i];
				end
				else
				begin
					stage1 <= pinIn[i];
					stage2 <= stage1;
				end
			end
			assign pinSync[i] = stage2;
		end
	endgenerate

endmodule

/* File: hdl/tcbsc_bus_cond.sv */
// Clock edge, start and stop detection on the synchronised upstream bus
`timescale 1ns/1ps
module tcbsc_bus_cond
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                sclS,
	input  wire logic                sdaS,
	output tcbsc_pkg::tcbsc_cond_type cond
);

	logic sclPrev;
	logic sdaPrev;

	// ****************************************
	// Previous samples
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			sclPrev <= sclS;
			sdaPrev <= sdaS;
		end
	end

	// ****************************************
	// Events, from live and previous samples
	// ****************************************
	// Unregistered: data line answer must land inside one bus clock low phase
	// Data moving while clock stays high marks start or stop
	always_comb
	begin
		if (rst)
			cond = tcbsc_pkg::COND_RESET;
		else
		begin
			cond.sclRise = sclS & ~sclPrev;
			cond.sclFall = ~sclS & sclPrev;
			cond.start   = sclS & sclPrev & sdaPrev & ~sdaS;
			cond.stop    = sclS & sclPrev & ~sdaPrev & sdaS;
			cond.sclHigh = sclS;
			cond.sda     = sdaS;
		end
	end

endmodule

/* File: hdl/tcbsc_switch_ctrl.sv */
// Bus target and control register of the two-channel bus switch
`timescale 1ns/1ps
module tcbsc_switch_ctrl
(
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic       chan0IrqInN,
	input  wire logic       chan1IrqInN,
	input  wire logic       addrSelectLow,
	input  wire logic       addrSelectHigh,
	input  wire logic       resetInN,
	output logic      [1:0] downstreamPairEnable,
	output logic            combIrqOut,
	output logic            combIrqOe
);

	tcbsc_pkg::tcbsc_pins_type  pinsRaw;
	tcbsc_pkg::tcbsc_pins_type  pinsSync;
	tcbsc_pkg::tcbsc_cond_type  cond;
	tcbsc_pkg::tcbsc_state_type state;
	tcbsc_pkg::tcbsc_ctrl_type  ctrl;
	tcbsc_pkg::tcbsc_ctrl_type  readByte;
	logic                       localRst;
	logic [3:0]                 bitCnt;
	logic [7:0]                 rxShift;
	logic [7:0]                 txShift;
	logic [1:0]                 irqPending;
	logic                       addrMatch;
	logic                       byteDone;
	logic                       wrStore;
	logic                       loadTx;
	logic                       next_sdaOe;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (localRst);

	// ****************************************
	// Pin synchronisation
	// ****************************************
	assign pinsRaw = {sclIn, sdaIn, chan1IrqInN, chan0IrqInN, resetInN,
		addrSelectHigh, addrSelectLow};

	tcbsc_sync #(
		.WIDTH     (tcbsc_pkg::PINS_W),
		.RESET_VAL (tcbsc_pkg::PINS_RESET)
	) u_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pinIn    (pinsRaw),
		.pinSync  (pinsSync)
	);

	// Reset pin acts like the core reset once synchronised
	assign localRst = sys_rst | ~pinsSync.rstN;

	tcbsc_bus_cond u_cond (
		.core_clk (core_clk),
		.rst      (localRst),
		.sclS     (pinsSync.scl),
		.sdaS     (pinsSync.sda),
		.cond     (cond)
	);

	// ****************************************
	// Decode helpers
	// ****************************************
	assign addrMatch = rxShift[7:1] == {tcbsc_pkg::ADDR_UPPER,
		pinsSync.addrHigh, pinsSync.addrLow};
	assign byteDone  = cond.sclFall && (bitCnt == tcbsc_pkg::BIT_CNT_FULL);
	assign wrStore   = (state == tcbsc_pkg::ST_WR_DATA) && byteDone;
	assign loadTx    = cond.sclFall && (((state == tcbsc_pkg::ST_ADDR_ACK) && rxShift[0])
		|| (state == tcbsc_pkg::ST_RD_ACK));

	// Inputs are sampled regardless of channel selection
	assign irqPending = ~{pinsSync.irq1N, pinsSync.irq0N};

	assign readByte.rsvdHigh = tcbsc_pkg::RSVD_VALUE;
	assign readByte.irq      = irqPending;
	assign readByte.rsvdLow  = tcbsc_pkg::RSVD_VALUE;
	assign readByte.sel      = ctrl.sel;

	// ****************************************
	// Bus state machine
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (localRst)
		begin
			state  <= tcbsc_pkg::ST_IDLE;
			bitCnt <= tcbsc_pkg::BIT_CNT_RESET;
		end
		else if (cond.start)
		begin
			state  <= tcbsc_pkg::ST_ADDR;
			bitCnt <= tcbsc_pkg::BIT_CNT_RESET;
		end
		else if (cond.stop)
			state <= tcbsc_pkg::ST_IDLE;
		else
		begin
			case (state)
				tcbsc_pkg::ST_ADDR,
				tcbsc_pkg::ST_WR_DATA:
				begin
					if (cond.sclRise)
						bitCnt <= bitCnt + 4'h1;
					else if (byteDone)
					begin
						bitCnt <= tcbsc_pkg::BIT_CNT_RESET;
						if (state == tcbsc_pkg::ST_WR_DATA)
							state <= tcbsc_pkg::ST_WR_ACK;
						else if (addrMatch)
							state <= tcbsc_pkg::ST_ADDR_ACK;
						else
							state <= tcbsc_pkg::ST_IGNORE;
					end
				end
				tcbsc_pkg::ST_ADDR_ACK:
				begin
					if (cond.sclFall && rxShift[0])
						state <= tcbsc_pkg::ST_RD_DATA;
					else if (cond.sclFall)
						state <= tcbsc_pkg::ST_WR_DATA;
				end
				tcbsc_pkg::ST_WR_ACK:
				begin
					// No byte limit: keep taking bytes until stop
					if (cond.sclFall)
						state <= tcbsc_pkg::ST_WR_DATA;
				end
				tcbsc_pkg::ST_RD_DATA:
				begin
					if (cond.sclFall && bitCnt == tcbsc_pkg::BIT_CNT_TXEND)
					begin
						state  <= tcbsc_pkg::ST_RD_ACK;
						bitCnt <= tcbsc_pkg::BIT_CNT_RESET;
					end
					else if (cond.sclFall)
						bitCnt <= bitCnt + 4'h1;
				end
				tcbsc_pkg::ST_RD_ACK:
				begin
					if (cond.sclRise && cond.sda)
						state <= tcbsc_pkg::ST_IGNORE;
					else if (cond.sclFall)
						state <= tcbsc_pkg::ST_RD_DATA;
				end
				default:
					state <= state;
			endcase
		end
	end

	// ****************************************
	// Receive and transmit shifters
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (localRst)
			rxShift <= 8'h00;
		else if (cond.sclRise && ((state == tcbsc_pkg::ST_ADDR)
			|| (state == tcbsc_pkg::ST_WR_DATA)))
			rxShift <= {rxShift[6:0], cond.sda};
	end

	// Each read byte is rebuilt so later bytes show fresh input state
	always_ff @(posedge core_clk)
	begin
		if (localRst)
			txShift <= 8'h00;
		else if (loadTx)
			txShift <= readByte;
		else if (cond.sclFall && state == tcbsc_pkg::ST_RD_DATA)
			txShift <= {txShift[6:0], 1'b0};
	end

	// ****************************************
	// Control register
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (localRst)
			ctrl <= tcbsc_pkg::CTRL_RESET;
		else
		begin
			if (wrStore)
				ctrl.sel <= rxShift[1:0];
			if (loadTx)
				ctrl.irq <= irqPending;
		end
	end

	// Selection waits for stop so downstream lines are idle when joined
	always_ff @(posedge core_clk)
	begin
		if (localRst)
			downstreamPairEnable <= tcbsc_pkg::SEL_RESET;
		else if (cond.stop)
			downstreamPairEnable <= ctrl.sel;
	end

	// ****************************************
	// Data line drive
	// ****************************************
	always_comb
	begin
		case (state)
			tcbsc_pkg::ST_ADDR_ACK,
			tcbsc_pkg::ST_WR_ACK:
				next_sdaOe = 1'b1;
			tcbsc_pkg::ST_RD_DATA:
				next_sdaOe = ~txShift[7];
			default:
				next_sdaOe = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (localRst)
			sdaOe <= 1'b0;
		else
			sdaOe <= next_sdaOe;
	end

	assign sdaOut = 1'b0;

	// ****************************************
	// Combined interrupt output
	// ****************************************
	// No pulse filter: short glitches pass straight through
	always_ff @(posedge core_clk)
	begin
		if (localRst)
			combIrqOe <= 1'b0;
		else
			combIrqOe <= |irqPending;
	end

	assign combIrqOut = 1'b0;

	// ****************************************
	// Checks
	// ****************************************

	property p_byteFrame;
		(state == tcbsc_pkg::ST_WR_DATA) && cond.sclFall && bitCnt == 4'h8
			&& !cond.start |=> state == tcbsc_pkg::ST_WR_ACK;
	endproperty
	a_byteFrame: assert property (p_byteFrame)
		else $error("write byte not followed by ack slot");

	property p_ackHold;
		((state == tcbsc_pkg::ST_WR_ACK) || (state == tcbsc_pkg::ST_ADDR_ACK))
			&& cond.sclRise |-> sdaOe ##1 sdaOe;
	endproperty
	a_ackHold: assert property (p_ackHold)
		else $error("ack not held low during clock high");

	property p_releaseTx;
		(state == tcbsc_pkg::ST_RD_ACK) && ($past(state) == tcbsc_pkg::ST_RD_ACK)
			|-> !sdaOe;
	endproperty
	a_releaseTx: assert property (p_releaseTx)
		else $error("data line driven in master ack slot");

	property p_nackEnd;
		(state == tcbsc_pkg::ST_RD_ACK) && cond.sclRise && cond.sda
			|=> (state == tcbsc_pkg::ST_IGNORE) ##1 !sdaOe [*2];
	endproperty
	a_nackEnd: assert property (p_nackEnd)
		else $error("line not released after nack");

	property p_direction;
		(state == tcbsc_pkg::ST_ADDR_ACK) && cond.sclFall |=>
			state == ($past(rxShift[0]) ? tcbsc_pkg::ST_RD_DATA : tcbsc_pkg::ST_WR_DATA);
	endproperty
	a_direction: assert property (p_direction)
		else $error("direction bit misread");

	property p_store;
		wrStore |=> ctrl.sel == $past(rxShift[1:0]) ##0 ctrl.rsvdLow == 2'h0;
	endproperty
	a_store: assert property (p_store)
		else $error("written byte not stored");

	property p_applyAtStop;
		cond.stop |=> downstreamPairEnable == $past(ctrl.sel);
	endproperty
	a_applyAtStop: assert property (p_applyAtStop)
		else $error("selection not applied at stop");

	property p_holdNoStop;
		!cond.stop |=> $stable(downstreamPairEnable);
	endproperty
	a_holdNoStop: assert property (p_holdNoStop)
		else $error("selection changed without stop");

	property p_resetValue;
		$fell(localRst) |-> (ctrl == 8'h00) && (downstreamPairEnable == 2'h0)
			&& (state == tcbsc_pkg::ST_IDLE);
	endproperty
	a_resetValue: assert property (p_resetValue)
		else $error("defaults not restored by reset");

	property p_irqOut;
		(!pinsSync.irq0N || !pinsSync.irq1N) |=> combIrqOe;
	endproperty
	a_irqOut: assert property (p_irqOut)
		else $error("combined interrupt not asserted");

	property p_readByte;
		loadTx |=> txShift == {2'h0, $past(irqPending), 2'h0, $past(ctrl.sel)};
	endproperty
	a_readByte: assert property (p_readByte)
		else $error("read byte wrong");

	property p_noMatch;
		(state == tcbsc_pkg::ST_IGNORE) && ($past(state) == tcbsc_pkg::ST_IGNORE)
			|-> !sdaOe;
	endproperty
	a_noMatch: assert property (p_noMatch)
		else $error("line driven while ignoring");

	c_writeStop: cover property (wrStore ##[1:1000] cond.stop);
	c_readNack: cover property ((state == tcbsc_pkg::ST_RD_ACK) && cond.sclRise
		&& cond.sda);
	c_bothIrq: cover property (loadTx && irqPending == 2'h3);
	c_bothChan: cover property (downstreamPairEnable == 2'h3);

endmodule

/* File: verif/tcbsc_master_model.sv */
// Upstream bus master model facing the switch control target
`timescale 1ns/1ps
module tcbsc_master_model
(
	input  wire logic       core_clk,
	input  wire logic       sdaWire,
	output logic            sclOut,
	output logic            sdaPull,
	output logic            resToggle,
	output logic      [7:0] resData
);
	// ****************
	// Bit and frame tasks
	// ****************
	initial
	begin
		sclOut = 1'b1;
		sdaPull = 1'b0;
		resToggle = 1'b0;
		resData = 8'h00;
	end

	// Sample at end of high phase: target answers some cycles late
	task automatic bitCycle(input logic b, output logic got);
		@(negedge core_clk);
		sclOut <= 1'b0;
		repeat (2) @(negedge core_clk);
		sdaPull <= ~b;
		repeat (2) @(negedge core_clk);
		sclOut <= 1'b1;
		repeat (3) @(negedge core_clk);
		got = sdaWire;
	endtask

	task automatic start();
		@(negedge core_clk);
		sdaPull <= 1'b1;
		repeat (4) @(negedge core_clk);
	endtask

	task automatic stop();
		@(negedge core_clk);
		sclOut <= 1'b0;
		repeat (2) @(negedge core_clk);
		sdaPull <= 1'b1;
		repeat (2) @(negedge core_clk);
		sclOut <= 1'b1;
		repeat (2) @(negedge core_clk);
		sdaPull <= 1'b0;
		repeat (6) @(negedge core_clk);
	endtask

	task automatic report(input logic [7:0] v);
		resData <= v;
		resToggle <= ~resToggle;
	endtask

	task automatic writeByte(input logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
		begin
			bitCycle(d[i], g);
		end
		bitCycle(1'b1, g);
		report({7'h00, ~g});
	endtask

	task automatic readByte(input logic last);
		logic       g;
		logic [7:0] d;
		for (int i = 7; i >= 0; i--)
		begin
			bitCycle(1'b1, g);
			d[i] = g;
		end
		bitCycle(last, g);
		report(d);
	endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench of the two-channel bus switch control block
`timescale 1ns/1ps
module tb_top;
	logic        core_clk;
	logic        sys_rst;
	logic        sclIn;
	logic        sdaWire;
	logic        sdaPull;
	logic        sdaOe;
	logic        sdaOut;
	logic        combIrqOut;
	logic        combIrqWire;
	logic        chan0IrqInN;
	logic        chan1IrqInN;
	logic        addrSelectLow;
	logic        addrSelectHigh;
	logic        resetInN;
	logic [1:0]  downstreamPairEnable;
	logic        combIrqOe;
	logic        resToggle;
	logic        seenToggle;
	logic [7:0]  resData;
	logic [7:0]  expQ[$];
	logic [1:0]  curSel;
	logic [1:0]  irqN;
	logic [6:0]  devAddr;
	logic [31:0] rnd;
	int          seed;
	int          badCount;
	int          checksDone;

	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;

	// Open-drain lines with pull-ups: low only where a driver is enabled
	assign sdaWire     = ~sdaPull & (sdaOe ? sdaOut : 1'b1);
	assign combIrqWire = combIrqOe ? combIrqOut : 1'b1;
	assign devAddr = {tcbsc_pkg::ADDR_UPPER, addrSelectHigh, addrSelectLow};

	tcbsc_switch_ctrl i_tcbsc_switch_ctrl
	(
		.core_clk             (core_clk),
		.sys_rst              (sys_rst),
		.sclIn                (sclIn),
		.sdaIn                (sdaWire),
		.sdaOut               (sdaOut),
		.sdaOe                (sdaOe),
		.chan0IrqInN          (chan0IrqInN),
		.chan1IrqInN          (chan1IrqInN),
		.addrSelectLow        (addrSelectLow),
		.addrSelectHigh       (addrSelectHigh),
		.resetInN             (resetInN),
		.downstreamPairEnable (downstreamPairEnable),
		.combIrqOut           (combIrqOut),
		.combIrqOe            (combIrqOe)
	);

	tcbsc_master_model i_tcbsc_master_model
	(
		.core_clk  (core_clk),
		.sdaWire   (sdaWire),
		.sclOut    (sclIn),
		.sdaPull   (sdaPull),
		.resToggle (resToggle),
		.resData   (resData)
	);

	// ****************
	// Checking and report
	// ****************
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checksDone++;
		if (got !== exp)
		begin
			badCount++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		if (badCount == 0 && checksDone > 0)
		begin
			$display("TB: PASS");
		end
		else
		begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Oldest note is matched against each bus result
	always @(posedge core_clk)
	begin
		if (resToggle !== seenToggle)
		begin
			seenToggle = resToggle;
			if (expQ.size() == 0)
				check("busQueue", 8'h00, 8'hFF);
			else
				check("busResult", expQ.pop_front(), resData);
		end
	end

	// ****************
	// Transfers
	// ****************
	task automatic writeCtl(input logic [6:0] a, input int n, input logic [7:0] d0,
		input logic [7:0] d1);
		logic hit;
		hit = (a === devAddr);
		i_tcbsc_master_model.start();
		expQ.push_back({7'h00, hit});
		i_tcbsc_master_model.writeByte({a, 1'b0});
		for (int k = 0; k < n; k++)
		begin
			expQ.push_back({7'h00, hit});
			i_tcbsc_master_model.writeByte(k == 0 ? d0 : d1);
		end
		check("selBeforeStop", {6'h00, curSel}, {6'h00, downstreamPairEnable});
		i_tcbsc_master_model.stop();
		if (hit)
			curSel = (n == 1) ? d0[1:0] : d1[1:0];
		check("selAfterStop", {6'h00, curSel}, {6'h00, downstreamPairEnable});
	endtask

	task automatic readCtl(input logic [7:0] e);
		i_tcbsc_master_model.start();
		expQ.push_back(8'h01);
		i_tcbsc_master_model.writeByte({devAddr, 1'b1});
		expQ.push_back(e);
		i_tcbsc_master_model.readByte(1'b0);
		expQ.push_back(e);
		i_tcbsc_master_model.readByte(1'b1);
		i_tcbsc_master_model.stop();
		check("dataReleased", 8'h00, {7'h00, sdaOe});
	endtask

	initial
	begin
		repeat (100000) @(posedge core_clk);
		badCount++;
		results();
	end

	initial
	begin
		seed = 1;
		badCount = 0;
		checksDone = 0;
		curSel = 2'h0;
		seenToggle = 1'b0;
		sys_rst = 1'b1;
		{chan1IrqInN, chan0IrqInN} = 2'h3;
		{addrSelectHigh, addrSelectLow} = 2'h0;
		resetInN = 1'b1;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge core_clk);
		check("selReset", 8'h00, {6'h00, downstreamPairEnable});
		readCtl(8'h00);
		writeCtl(devAddr ^ 7'h01, 1, 8'h03, 8'h00);
		// Every selection and interrupt pattern, single and multi-byte writes
		for (int i = 0; i < 8; i++)
		begin
			rnd = $random(seed);
			{addrSelectHigh, addrSelectLow} = rnd[1:0];
			irqN = 2'(i);
			{chan1IrqInN, chan0IrqInN} = irqN;
			repeat (4) @(negedge core_clk);
			check("combIrq", {7'h00, &irqN}, {7'h00, combIrqWire});
			writeCtl(devAddr, 1 + i / 4, {rnd[15:10], ~2'(i)}, {rnd[23:18], 2'(i)});
			readCtl({2'h0, ~irqN, 2'h0, curSel});
		end
		// Reset pin drops the selection and the bus state
		writeCtl(devAddr, 1, 8'h03, 8'h00);
		{chan1IrqInN, chan0IrqInN} = 2'h3;
		resetInN = 1'b0;
		repeat (4) @(negedge core_clk);
		resetInN = 1'b1;
		curSel = 2'h0;
		repeat (4) @(negedge core_clk);
		check("selPinReset", 8'h00, {6'h00, downstreamPairEnable});
		readCtl(8'h00);
		// Pending channel found by a read is then selected for polling
		chan1IrqInN = 1'b0;
		repeat (4) @(negedge core_clk);
		readCtl(8'h20);
		writeCtl(devAddr, 1, 8'h02, 8'h00);
		repeat (20) @(negedge core_clk);
		results();
	end
endmodule
